//--- common/irs_pkg.sv
// irs_pkg: offsets, fields, reset values and sizes of the router setup.
// assumes one core clock; no timing constants needed.
package irs_pkg;

    localparam int GROUPS         = 11;
    localparam int GROUP_WIRES    = 4;
    localparam int GROUP_INPUTS   = 44;
    localparam int SINGLES        = 14;
    localparam int ENTRIES_MAX    = 32;
    localparam int ENTRIES_SMALL  = 24;
    localparam int FIELDS_PER_REG = 4;
    localparam int GROUP_REGS     = 3;
    localparam int SINGLE_REGS    = 4;

    // configuration space (index/data pair)
    localparam logic [7:0] CFG_FEATURE       = 8'h00;
    localparam logic [7:0] CFG_BAR_LO        = 8'h01;
    localparam logic [7:0] CFG_BAR_HI        = 8'h02;
    localparam logic [7:0] CFG_GROUP_ROUTE0  = 8'h03;
    localparam logic [7:0] CFG_SINGLE_ROUTE0 = 8'h06;

    // feature control bits
    localparam int FEAT_DECODE  = 0;
    localparam int FEAT_ENTRIES = 1;
    localparam int FEAT_ID_EXT  = 2;
    localparam int FEAT_WAKE    = 3;
    localparam int FEAT_FORWARD = 4;
    localparam int FEAT_WIDTH   = 5;

    // base address register
    localparam logic [31:0] BAR_LO_RESET = 32'hfec0_0008;
    localparam logic [31:0] BAR_HI_RESET = 32'h0000_0000;
    localparam int          BAR_MEM_BIT  = 3;
    localparam int          BAR_ADDR_LSB = 5;
    localparam int          WIN_SPAN_LSB = 6;

    // routing fields inside one byte
    localparam int GRP_SEL_W    = 3;
    localparam int GRP_SWZ_LSB  = 4;
    localparam int GRP_SWZ_W    = 2;
    localparam int PIN_W        = 5;

    // memory window offsets
    localparam logic [5:0] WIN_SELECT     = 6'h00;
    localparam logic [5:0] WIN_DATA       = 6'h10;
    localparam logic [5:0] WIN_PIN_ASSERT = 6'h20;

    // indirect registers
    localparam logic [7:0] IND_UNIT_ID     = 8'h00;
    localparam logic [7:0] IND_VERSION     = 8'h01;
    localparam logic [7:0] IND_ARBITRATION = 8'h02;
    localparam logic [7:0] IND_REDIR_BASE  = 8'h10;

    localparam int         ID_LSB        = 24;
    localparam int         ID_UPPER_LSB  = 28;
    localparam logic [3:0] UNIT_ID       = 4'h3; // arbitrary value
    localparam logic [3:0] UPPER_ID      = 4'h5; // arbitrary value
    localparam logic [7:0] VERSION_CODE  = 8'h11; // arbitrary value
    localparam int         PIN_ASSERT_BIT = 15;
    localparam int         MAXRED_LSB    = 16;
    localparam logic [7:0] MAXRED_SMALL  = 8'h17;
    localparam logic [7:0] MAXRED_LARGE  = 8'h1f;

    // redirection entry fields
    localparam int RED_TRIG_BIT = 15;
    localparam int RED_MASK_BIT = 16;
    localparam int RED_DEST_LSB = 24;

endpackage

//--- logic/irs_map.sv
// irs_map: folds the group and single-wire interrupt inputs onto the 32 router pins.
// assumes synchronised inputs; output is combinational.
`timescale 1ns/1ps
`default_nettype none

module irs_map (
    input  wire logic [43:0] group_irq,
    input  wire logic [13:0] single_irq,
    input  wire logic [32:0] group_sel,
    input  wire logic [21:0] group_swz,
    input  wire logic [69:0] single_pin,
    output logic      [31:0] pin_level
);

    logic [43:0] rotated;

    // rotate each group's four wires by its swizzle
    genvar g;
    genvar k;
    generate
        for (g = 0; g < irs_pkg::GROUPS; g++) begin : g_grp
            for (k = 0; k < irs_pkg::GROUP_WIRES; k++) begin : g_wire
                logic [1:0] src;
                assign src = 2'(k) + group_swz[2*g +: 2];
                assign rotated[4*g+k] = group_irq[4*g + src];
            end
        end
    endgenerate

    always_comb begin
        pin_level = 32'h0000_0000;
        for (int i = 0; i < irs_pkg::GROUPS; i++) begin
            for (int w = 0; w < irs_pkg::GROUP_WIRES; w++) begin
                // sources sharing a pin are or-ed
                pin_level[{group_sel[3*i +: 3], 2'(w)}] |= rotated[4*i+w];
            end
        end
        for (int s = 0; s < irs_pkg::SINGLES; s++) begin
            pin_level[single_pin[5*s +: 5]] |= single_irq[s];
        end
    end

endmodule

`default_nettype wire

//--- logic/irs_top.sv
// irs_top: registers, memory window and delivery of the interrupt router.
// assumes strobes from mclk logic; irq inputs are asynchronous pins.
//
// How it works
// - index 0x00 reads 4-bit identifier, bits 27:24
// - bits 31:28 upper nibble when extension set
// - index 0x01 returns fixed 8-bit version code
// - version bit 15 reads one, read-only
// - version 23:16 gives entries minus one
// - index 0x02 arbitration field unsupported
// - feature bit 0 enables memory window decode
// - feature bit 2 widens identifier to 8 bits
// - feature bit 3 sends wake with each delivered interrupt
// - feature bit 4 forwards masked interrupts onward
// - base address resets to its default window
// - 58 inputs map onto 32 or 24 entries
// - eleven four-wire groups plus fourteen single wires
// - per-group group/swizzle, per-single pin number
// - entries hold mask, vector, destination, trigger
// - swizzle rotates a group's four wires
// - group number picks four consecutive pins
// - select at 0x00, data at 0x10
`timescale 1ns/1ps
`default_nettype none

module irs_top (
    input  wire logic        mclk,
    input  wire logic        reset_n,
    input  wire logic        cfg_wr,
    input  wire logic        cfg_rd,
    input  wire logic [7:0]  cfg_index,
    input  wire logic [31:0] cfg_wdata,
    output logic      [31:0] cfg_rdata,
    output logic             cfg_rvalid,
    input  wire logic        mem_wr,
    input  wire logic        mem_rd,
    input  wire logic [31:0] mem_addr,
    input  wire logic [31:0] mem_wdata,
    output logic      [31:0] mem_rdata,
    output logic             mem_rvalid,
    output logic             mem_claim,
    input  wire logic [43:0] group_irq,
    input  wire logic [13:0] single_irq,
    output logic             deliver_valid,
    output logic      [4:0]  deliver_pin,
    output logic      [7:0]  deliver_vector,
    output logic      [7:0]  deliver_dest,
    output logic             deliver_level,
    output logic             wake_message,
    output logic             forward_valid,
    output logic      [4:0]  forward_pin
);

    logic [31:0] feature_control;
    logic [31:0] bar_lo;
    logic [31:0] bar_hi;
    logic [31:0] group_route  [irs_pkg::GROUP_REGS];
    logic [31:0] single_route [irs_pkg::SINGLE_REGS];
    logic [31:0] next_feature_control;
    logic [31:0] next_bar_lo;
    logic [31:0] next_bar_hi;
    logic [31:0] next_group_route  [irs_pkg::GROUP_REGS];
    logic [31:0] next_single_route [irs_pkg::SINGLE_REGS];

    logic        large_table;
    logic [5:0]  entry_count;
    logic [31:0] active_pins;

    assign large_table = feature_control[irs_pkg::FEAT_ENTRIES];
    assign entry_count = large_table ? 6'h20 : 6'h18;
    assign active_pins = large_table ? 32'hffff_ffff : 32'h00ff_ffff;

    // offset lies inside the live redirection table
    function automatic logic entry_hit(input logic [7:0] sel, input logic [5:0] count);
        logic [7:0] off;
        off = sel - irs_pkg::IND_REDIR_BASE;
        return (sel >= irs_pkg::IND_REDIR_BASE) && (off < {1'b0, count, 1'b0});
    endfunction

    function automatic logic [4:0] entry_index(input logic [7:0] sel);
        logic [7:0] off;
        off = sel - irs_pkg::IND_REDIR_BASE;
        return off[5:1];
    endfunction

    // configuration registers
    always_comb begin
        next_feature_control = feature_control;
        next_bar_lo          = bar_lo;
        next_bar_hi          = bar_hi;
        next_group_route     = group_route;
        next_single_route    = single_route;
        if (cfg_wr) begin
            if (cfg_index == irs_pkg::CFG_FEATURE) begin
                next_feature_control = {27'h0, cfg_wdata[irs_pkg::FEAT_WIDTH-1:0]};
            end
            if (cfg_index == irs_pkg::CFG_BAR_LO) begin
                next_bar_lo = {cfg_wdata[31:irs_pkg::BAR_ADDR_LSB], 1'b0,
                               cfg_wdata[irs_pkg::BAR_MEM_BIT], 3'h0};
            end
            if (cfg_index == irs_pkg::CFG_BAR_HI) begin
                next_bar_hi = cfg_wdata;
            end
            for (int i = 0; i < irs_pkg::GROUP_REGS; i++) begin
                if (cfg_index == irs_pkg::CFG_GROUP_ROUTE0 + 8'(i)) begin
                    for (int f = 0; f < irs_pkg::FIELDS_PER_REG; f++) begin
                        // fields beyond the last group stay zero
                        next_group_route[i][8*f +: 8] =
                            (i*4 + f < irs_pkg::GROUPS) ? (cfg_wdata[8*f +: 8] & 8'h37) : 8'h00;
                    end
                end
            end
            for (int i = 0; i < irs_pkg::SINGLE_REGS; i++) begin
                if (cfg_index == irs_pkg::CFG_SINGLE_ROUTE0 + 8'(i)) begin
                    for (int f = 0; f < irs_pkg::FIELDS_PER_REG; f++) begin
                        next_single_route[i][8*f +: 8] =
                            (i*4 + f < irs_pkg::SINGLES) ? (cfg_wdata[8*f +: 8] & 8'h1f) : 8'h00;
                    end
                end
            end
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            feature_control <= 32'h0000_0000;
            bar_lo          <= irs_pkg::BAR_LO_RESET;
            bar_hi          <= irs_pkg::BAR_HI_RESET;
            for (int i = 0; i < irs_pkg::GROUP_REGS; i++) begin
                group_route[i] <= 32'h0000_0000;
            end
            for (int i = 0; i < irs_pkg::SINGLE_REGS; i++) begin
                single_route[i] <= 32'h0000_0000;
            end
        end else begin
            feature_control <= next_feature_control;
            bar_lo          <= next_bar_lo;
            bar_hi          <= next_bar_hi;
            group_route     <= next_group_route;
            single_route    <= next_single_route;
        end
    end

    // memory window decode
    logic [5:0] win_off;
    assign win_off   = mem_addr[irs_pkg::WIN_SPAN_LSB-1:0];
    assign mem_claim = feature_control[irs_pkg::FEAT_DECODE] && bar_lo[irs_pkg::BAR_MEM_BIT]
                       && (bar_hi == 32'h0)
                       && (mem_addr[31:irs_pkg::WIN_SPAN_LSB] == bar_lo[31:irs_pkg::WIN_SPAN_LSB])
                       && (mem_wr || mem_rd);

    // select register and redirection table
    logic [7:0]  select;
    logic [7:0]  next_select;
    logic [7:0]  red_vector [irs_pkg::ENTRIES_MAX];
    logic [7:0]  red_dest   [irs_pkg::ENTRIES_MAX];
    logic [31:0] red_trig;
    logic [31:0] red_mask;
    logic [7:0]  next_red_vector [irs_pkg::ENTRIES_MAX];
    logic [7:0]  next_red_dest   [irs_pkg::ENTRIES_MAX];
    logic [31:0] next_red_trig;
    logic [31:0] next_red_mask;
    logic [31:0] assert_req;

    always_comb begin
        logic [4:0] n;
        n               = entry_index(select);
        next_select     = select;
        next_red_vector = red_vector;
        next_red_dest   = red_dest;
        next_red_trig   = red_trig;
        next_red_mask   = red_mask;
        assert_req      = 32'h0000_0000;
        if (mem_claim && mem_wr) begin
            if (win_off == irs_pkg::WIN_SELECT) begin
                next_select = mem_wdata[7:0];
            end
            // read-only indirect offsets fall through
            if (win_off == irs_pkg::WIN_DATA && entry_hit(select, entry_count)) begin
                if (select[0] == 1'b0) begin
                    next_red_vector[n] = mem_wdata[7:0];
                    next_red_trig[n]   = mem_wdata[irs_pkg::RED_TRIG_BIT];
                    next_red_mask[n]   = mem_wdata[irs_pkg::RED_MASK_BIT];
                end else begin
                    next_red_dest[n] = mem_wdata[irs_pkg::RED_DEST_LSB +: 8];
                end
            end
            if (win_off == irs_pkg::WIN_PIN_ASSERT && mem_wdata[7:0] < {2'h0, entry_count}) begin
                assert_req[mem_wdata[4:0]] = 1'b1;
            end
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            select   <= 8'h00;
            red_trig <= 32'h0000_0000;
            red_mask <= 32'hffff_ffff;
            for (int i = 0; i < irs_pkg::ENTRIES_MAX; i++) begin
                red_vector[i] <= 8'h00;
                red_dest[i]   <= 8'h00;
            end
        end else begin
            select     <= next_select;
            red_vector <= next_red_vector;
            red_dest   <= next_red_dest;
            red_trig   <= next_red_trig;
            red_mask   <= next_red_mask;
        end
    end

    // input synchronisers and routing
    logic [57:0] irq_meta;
    logic [57:0] irq_sync;
    logic [32:0] group_sel;
    logic [21:0] group_swz;
    logic [69:0] single_pin;
    logic [31:0] pin_level;

    genvar g;
    generate
        for (g = 0; g < irs_pkg::GROUPS; g++) begin : g_grp_fields
            assign group_sel[3*g +: 3] = group_route[g/4][8*(g%4) +: irs_pkg::GRP_SEL_W];
            assign group_swz[2*g +: 2] =
                group_route[g/4][8*(g%4) + irs_pkg::GRP_SWZ_LSB +: irs_pkg::GRP_SWZ_W];
        end
        for (g = 0; g < irs_pkg::SINGLES; g++) begin : g_single_fields
            assign single_pin[5*g +: 5] = single_route[g/4][8*(g%4) +: irs_pkg::PIN_W];
        end
    endgenerate

    irs_map u_map (
        .group_irq  (irq_sync[irs_pkg::GROUP_INPUTS-1:0]),
        .single_irq (irq_sync[57:irs_pkg::GROUP_INPUTS]),
        .group_sel  (group_sel),
        .group_swz  (group_swz),
        .single_pin (single_pin),
        .pin_level  (pin_level)
    );

    // pending pins and delivery
    logic [31:0] pin_prev;
    logic [31:0] pending;
    logic [31:0] next_pending;
    logic        next_deliver_valid;
    logic [4:0]  next_deliver_pin;
    logic [7:0]  next_deliver_vector;
    logic [7:0]  next_deliver_dest;
    logic        next_deliver_level;
    logic        next_wake_message;
    logic        next_forward_valid;
    logic [4:0]  next_forward_pin;

    always_comb begin
        logic [4:0]  p;
        logic [31:0] clear;
        p     = 5'h00;
        clear = 32'h0000_0000;
        for (int i = irs_pkg::ENTRIES_MAX-1; i >= 0; i--) begin
            if (pending[i]) begin
                p = 5'(i);
            end
        end
        if (pending != 32'h0000_0000) begin
            clear[p] = 1'b1;
        end
        next_deliver_valid  = 1'b0;
        next_deliver_pin    = deliver_pin;
        next_deliver_vector = deliver_vector;
        next_deliver_dest   = deliver_dest;
        next_deliver_level  = deliver_level;
        next_wake_message   = 1'b0;
        next_forward_valid  = 1'b0;
        next_forward_pin    = forward_pin;
        if (pending != 32'h0000_0000) begin
            if (!red_mask[p]) begin
                next_deliver_valid  = 1'b1;
                next_deliver_pin    = p;
                next_deliver_vector = red_vector[p];
                next_deliver_dest   = red_dest[p];
                next_deliver_level  = red_trig[p];
                next_wake_message   = feature_control[irs_pkg::FEAT_WAKE];
            end else if (feature_control[irs_pkg::FEAT_FORWARD]) begin
                next_forward_valid = 1'b1;
                next_forward_pin   = p;
            end
        end
        // the set is applied last so a new edge beats the clear
        next_pending = ((pending & ~clear) | ((pin_level & ~pin_prev) | assert_req))
                       & active_pins;
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            irq_meta       <= '0;
            irq_sync       <= '0;
            pin_prev       <= 32'h0000_0000;
            pending        <= 32'h0000_0000;
            deliver_valid  <= 1'b0;
            deliver_pin    <= 5'h00;
            deliver_vector <= 8'h00;
            deliver_dest   <= 8'h00;
            deliver_level  <= 1'b0;
            wake_message   <= 1'b0;
            forward_valid  <= 1'b0;
            forward_pin    <= 5'h00;
        end else begin
            irq_meta       <= {single_irq, group_irq};
            irq_sync       <= irq_meta;
            pin_prev       <= pin_level;
            pending        <= next_pending;
            deliver_valid  <= next_deliver_valid;
            deliver_pin    <= next_deliver_pin;
            deliver_vector <= next_deliver_vector;
            deliver_dest   <= next_deliver_dest;
            deliver_level  <= next_deliver_level;
            wake_message   <= next_wake_message;
            forward_valid  <= next_forward_valid;
            forward_pin    <= next_forward_pin;
        end
    end

    // read paths, answered one cycle after the strobe
    logic [31:0] ind_rdata;
    logic [31:0] cfg_value;
    logic [31:0] next_cfg_rdata;
    logic [31:0] next_mem_rdata;
    logic        next_cfg_rvalid;
    logic        next_mem_rvalid;

    always_comb begin
        logic [4:0] n;
        n         = entry_index(select);
        ind_rdata = 32'h0000_0000;
        if (select == irs_pkg::IND_UNIT_ID) begin
            ind_rdata[irs_pkg::ID_LSB +: 4] = irs_pkg::UNIT_ID;
            if (feature_control[irs_pkg::FEAT_ID_EXT]) begin
                ind_rdata[irs_pkg::ID_UPPER_LSB +: 4] = irs_pkg::UPPER_ID;
            end
        end else if (select == irs_pkg::IND_VERSION) begin
            ind_rdata[7:0]                     = irs_pkg::VERSION_CODE;
            ind_rdata[irs_pkg::PIN_ASSERT_BIT] = 1'b1;
            ind_rdata[irs_pkg::MAXRED_LSB +: 8] =
                large_table ? irs_pkg::MAXRED_LARGE : irs_pkg::MAXRED_SMALL;
        end else if (entry_hit(select, entry_count)) begin
            if (select[0] == 1'b0) begin
                ind_rdata[7:0]                   = red_vector[n];
                ind_rdata[irs_pkg::RED_TRIG_BIT] = red_trig[n];
                ind_rdata[irs_pkg::RED_MASK_BIT] = red_mask[n];
            end else begin
                ind_rdata[irs_pkg::RED_DEST_LSB +: 8] = red_dest[n];
            end
        end
        // arbitration reads zero: no serial bus to arbitrate
    end

    always_comb begin
        cfg_value = 32'h0000_0000;
        if (cfg_index == irs_pkg::CFG_FEATURE) begin
            cfg_value = feature_control;
        end else if (cfg_index == irs_pkg::CFG_BAR_LO) begin
            cfg_value = bar_lo;
        end else if (cfg_index == irs_pkg::CFG_BAR_HI) begin
            cfg_value = bar_hi;
        end else if (cfg_index >= irs_pkg::CFG_GROUP_ROUTE0 &&
                     cfg_index < irs_pkg::CFG_SINGLE_ROUTE0) begin
            cfg_value = group_route[2'(cfg_index - irs_pkg::CFG_GROUP_ROUTE0)];
        end else if (cfg_index >= irs_pkg::CFG_SINGLE_ROUTE0 &&
                     cfg_index < irs_pkg::CFG_SINGLE_ROUTE0 + 8'h04) begin
            cfg_value = single_route[2'(cfg_index - irs_pkg::CFG_SINGLE_ROUTE0)];
        end
        next_cfg_rvalid = cfg_rd;
        next_cfg_rdata  = cfg_rd ? cfg_value : cfg_rdata;
        next_mem_rvalid = mem_claim && mem_rd;
        next_mem_rdata  = mem_rdata;
        if (mem_claim && mem_rd) begin
            if (win_off == irs_pkg::WIN_SELECT) begin
                next_mem_rdata = {24'h0, select};
            end else if (win_off == irs_pkg::WIN_DATA) begin
                next_mem_rdata = ind_rdata;
            end else begin
                next_mem_rdata = 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            cfg_rdata  <= 32'h0000_0000;
            cfg_rvalid <= 1'b0;
            mem_rdata  <= 32'h0000_0000;
            mem_rvalid <= 1'b0;
        end else begin
            cfg_rdata  <= next_cfg_rdata;
            cfg_rvalid <= next_cfg_rvalid;
            mem_rdata  <= next_mem_rdata;
            mem_rvalid <= next_mem_rvalid;
        end
    end

endmodule

`default_nettype wire

//--- dv/irs_top_props.sv
// irs_top_props: port checker for irs_top.
// assumes one clock domain; feature bits are shadowed from config writes.
`timescale 1ns/1ps
`default_nettype none
module irs_props (
    input wire logic        mclk,
    input wire logic        reset_n,
    input wire logic        cfg_wr,
    input wire logic        cfg_rd,
    input wire logic [7:0]  cfg_index,
    input wire logic [31:0] cfg_wdata,
    input wire logic [31:0] cfg_rdata,
    input wire logic        cfg_rvalid,
    input wire logic        mem_rd,
    input wire logic        mem_claim,
    input wire logic        mem_rvalid,
    input wire logic        deliver_valid,
    input wire logic [4:0]  deliver_pin,
    input wire logic        wake_message,
    input wire logic        forward_valid
);
    logic [4:0] feat;
    logic [4:0] next_feat;
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    always_comb begin
        next_feat = feat;
        if (cfg_wr && cfg_index == 8'h00)
            next_feat = cfg_wdata[4:0];
    end
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n)
            feat <= 5'h00;
        else
            feat <= next_feat;
    end
    a_feat_readback: assert property (cfg_rd && cfg_index == 8'h00
        |=> cfg_rvalid && cfg_rdata == {27'h0, feat}) else $error("feature readback");
    a_mem_answer: assert property (mem_rd && mem_claim |=> mem_rvalid)
        else $error("claimed read unanswered");
    a_no_stray_data: assert property (!(mem_rd && mem_claim) |=> !mem_rvalid)
        else $error("unclaimed read answered");
    a_decode_gate: assert property (mem_claim |-> feat[0])
        else $error("claim with decode off");
    a_wake_follows: assert property (wake_message |-> deliver_valid && feat[3])
        else $error("stray wake");
    a_wake_sent: assert property (deliver_valid && feat[3] |-> wake_message)
        else $error("missing wake");
    a_forward_gate: assert property (forward_valid |-> feat[4])
        else $error("forward while disabled");
    a_small_table: assert property (deliver_valid && !feat[1] |-> deliver_pin < 5'd24)
        else $error("pin beyond small table");
endmodule
bind irs_top irs_props u_props (.mclk, .reset_n, .cfg_wr, .cfg_rd, .cfg_index, .cfg_wdata,
    .cfg_rdata, .cfg_rvalid, .mem_rd, .mem_claim, .mem_rvalid, .deliver_valid, .deliver_pin,
    .wake_message, .forward_valid);
`default_nettype wire

//--- dv/irs_host.sv
// irs_host: far-side sink that records deliveries and forwards.
// assumes one-cycle pulses.
`timescale 1ns/1ps
`default_nettype none
module irs_host (
    input  wire logic        mclk,
    input  wire logic        reset_n,
    input  wire logic        deliver_valid,
    input  wire logic [4:0]  deliver_pin,
    input  wire logic [7:0]  deliver_vector,
    input  wire logic [7:0]  deliver_dest,
    input  wire logic        forward_valid,
    input  wire logic [4:0]  forward_pin,
    output var int           n_del,
    output var int           n_fwd,
    output logic      [20:0] last_del,
    output logic      [4:0]  last_fwd
);
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            n_del <= 0;
            n_fwd <= 0;
        end else begin
            if (deliver_valid) begin
                n_del <= n_del + 1;
                last_del <= {deliver_pin, deliver_vector, deliver_dest};
            end
            if (forward_valid) begin
                n_fwd <= n_fwd + 1;
                last_fwd <= forward_pin;
            end
        end
    end
endmodule
`default_nettype wire

//--- dv/tb_top.sv
// tb_top: self-checking bench for irs_top with a host sink model.
// assumes the default window base.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        mclk, reset_n, cfg_wr, cfg_rd, mem_wr, mem_rd, cfg_rvalid, mem_rvalid;
    logic        mem_claim, deliver_valid, deliver_level, wake_message, forward_valid;
    logic [7:0]  cfg_index, deliver_vector, deliver_dest;
    logic [31:0] cfg_wdata, cfg_rdata, mem_addr, mem_wdata, mem_rdata, f;
    logic [43:0] group_irq;
    logic [13:0] single_irq;
    logic [4:0]  deliver_pin, forward_pin, last_fwd, p;
    logic [20:0] last_del;
    int          seed, err_count, n_checks, cyc, i, g, w, s, n0, m0, n_del, n_fwd;
    irs_top uut (.mclk, .reset_n, .cfg_wr, .cfg_rd, .cfg_index, .cfg_wdata, .cfg_rdata,
        .cfg_rvalid, .mem_wr, .mem_rd, .mem_addr, .mem_wdata, .mem_rdata, .mem_rvalid,
        .mem_claim, .group_irq, .single_irq, .deliver_valid, .deliver_pin, .deliver_vector,
        .deliver_dest, .deliver_level, .wake_message, .forward_valid, .forward_pin);
    irs_host host (.mclk, .reset_n, .deliver_valid, .deliver_pin, .deliver_vector,
        .deliver_dest, .forward_valid, .forward_pin, .n_del, .n_fwd, .last_del, .last_fwd);
    task automatic end_sim;
        if (err_count == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // a missing window answer reads as dead_0bad
    task automatic acc(input bit m, input bit wr, input logic [31:0] a, d, e);
        @(negedge mclk);
        {cfg_wr, cfg_rd, mem_wr, mem_rd} = {!m && wr, !m && !wr, m && wr, m && !wr};
        cfg_index = a[7:0];
        cfg_wdata = d;
        mem_addr = 32'hfec0_0000 | a;
        mem_wdata = d;
        @(negedge mclk);
        {cfg_wr, cfg_rd, mem_wr, mem_rd} = 4'h0;
        if (!wr)
            chk(m ? (mem_rvalid ? mem_rdata : 32'hdead_0bad) : cfg_rdata, e);
    endtask
    task automatic expect_del(input int c0, input bit yes, input logic [20:0] e);
        for (int k = 0; k < 8 && n_del == c0; k++)
            @(negedge mclk);
        chk(32'(n_del - c0), {31'h0, yes});
        if (yes)
            chk({11'h0, last_del}, {11'h0, e});
    endtask
    initial begin
        mclk = 0;
        forever #5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc++;
        if (cyc > 5000) begin
            err_count++;
            end_sim();
        end
    end
    initial begin
        seed = 86;
        {reset_n, cfg_wr, cfg_rd, mem_wr, mem_rd, cfg_index} = 0;
        {cfg_wdata, mem_addr, mem_wdata, group_irq, single_irq} = 0;
        repeat (5) @(posedge mclk);
        @(negedge mclk) reset_n = 1;
        acc(0, 0, 1, 0, 32'hfec0_0008);
        acc(1, 0, 'h10, 0, 32'hdead_0bad);
        acc(0, 1, 1, 32'hfec0_0008, 0);
        for (i = 0; i < 8; i++) begin
            f = (i == 7) ? 32'hffff_ffff : $random(seed) | 1;
            acc(0, 1, 0, f, 0);
            acc(0, 0, 0, 0, {27'h0, f[4:0]});
            for (int r = 0; r < 3; r++) begin
                acc(1, 1, 0, r, 0);
                acc(1, 1, 'h10, $random(seed), 0);
                acc(1, 0, 'h10, 0, r == 0 ? {f[2] ? irs_pkg::UPPER_ID : 4'h0,
                    irs_pkg::UNIT_ID, 24'h0} : r == 1 ? {8'h0, f[1] ? irs_pkg::MAXRED_LARGE
                    : irs_pkg::MAXRED_SMALL, 1'b1, 7'h0, irs_pkg::VERSION_CODE} : 0);
            end
        end
        acc(0, 1, 0, 32'h1b, 0);
        for (i = 0; i < 32; i++) begin
            f = {15'h0, i == 5, i == 3, 7'h0, 8'(i + 'h40)};
            acc(1, 1, 0, 'h10 + 2 * i, 0);
            acc(1, 1, 'h10, f, 0);
            acc(1, 0, 'h10, 0, f);
            acc(1, 1, 0, 'h11 + 2 * i, 0);
            acc(1, 1, 'h10, i << 24, 0);
        end
        n0 = n_del;
        acc(1, 1, 'h20, 3, 0);
        expect_del(n0, 1, {5'd3, 8'h43, 8'h03});
        chk(deliver_level, 1);
        n0 = n_del;
        m0 = n_fwd;
        acc(1, 1, 'h20, 5, 0);
        expect_del(n0, 0, 0);
        chk(32'(n_fwd - m0), 1);
        chk({27'h0, last_fwd}, 5);
        for (s = 0; s < 4; s++) begin
            g = $random(seed) & 7;
            g = (g == 1) ? 2 : g;
            w = $random(seed) & 3;
            acc(0, 1, 3, {26'h0, 2'(s), 1'b0, 3'(g)}, 0);
            p = 5'(4 * g + ((w - s) & 3));
            n0 = n_del;
            group_irq[w] = 1;
            expect_del(n0, 1, {p, 8'(p + 'h40), 3'h0, p});
            group_irq = 0;
            repeat (4) @(negedge mclk);
        end
        i = ($random(seed) & 15) % 14;
        acc(0, 1, 6 + i / 4, 31 << (8 * (i % 4)), 0);
        n0 = n_del;
        single_irq[i] = 1;
        expect_del(n0, 1, {5'd31, 8'h5f, 8'h1f});
        single_irq = 0;
        acc(0, 1, 0, 1, 0);
        n0 = n_del;
        acc(1, 1, 'h20, 28, 0);
        expect_del(n0, 0, 0);
        acc(1, 1, 'h20, 3, 0);
        expect_del(n0, 1, {5'd3, 8'h43, 8'h03});
        end_sim();
    end
endmodule
`default_nettype wire
